/* File: sim/chgport_cfg_tb.sv */
// Self-checking bench for the charging port configuration block.
`timescale 1ns/100ps
`include "chgport_defs.vh"
`default_nettype none
module chgport_cfg_tb;
  localparam NP = 4;
  localparam TICK = 10; // Shortened power-good unit keeps the run brief.
  localparam [15:0] VIDV = 16'hC0DE; // Arbitrary identity value.
  localparam [15:0] DIDV = 16'h0B0E; // Arbitrary identity value.
  localparam integer OC2N [0:3] = '{`CYC_UP(`OC2_T0_NS), `CYC_UP(`OC2_T1_NS),
    `CYC_UP(`OC2_T2_NS), `CYC_UP(`OC2_T3_NS)};
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, inhibit_n;
  logic [7:0] awaddr, araddr, gpio;
  logic [31:0] wdata;
  logic [NP-1:0] strap_dis, dcp, pwr_req, fault, comb;
  wire [31:0] rdata;
  wire [1:0] bresp, rresp, sda, scl;
  wire awready, wready, bvalid, arready, rvalid, compound, psw;
  wire [NP-1:0] oc_n, pin_i, pin_o, pin_oe, vend, vend2a, bc12, shrt, leg, oc2, oc3, pgood, pdis;
  wire [7:0] swap;
  integer bad_count, n_checks, i;

  chgport_cfg #(.NP(NP), .TICK_CYC(TICK), .VID_RST(VIDV), .DID_RST(DIDV)) dut (
    .MCLK_I(clk), .RST_N_I(rst_n),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
    .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
    .GLOBAL_CHARGE_INHIBIT_N_I(inhibit_n), .STRAP_DISABLE_I(strap_dis),
    .STRAP_NONREM_I(4'h0), .STRAP_CHARGE_I(4'h0), .PORT_DCP_I(dcp),
    .PORT_PWR_REQ_I(pwr_req), .OC_N_I(oc_n), .GPIO_I(gpio),
    .PORT_POWER_CONTROL_PIN_I(pin_i), .PORT_POWER_CONTROL_PIN_O(pin_o),
    .PORT_POWER_CONTROL_PIN_OE_O(pin_oe), .CHG_VENDOR_O(vend), .CHG_VENDOR_2A_O(vend2a),
    .CHG_BC12_O(bc12), .CHG_SHORT_O(shrt), .CHG_LEGACY_O(leg), .OC2_REPORT_O(oc2),
    .OC3_REPORT_O(oc3), .POWER_GOOD_O(pgood), .PORT_DISABLE_O(pdis),
    .DPDM_SWAP_O(swap), .COMPOUND_O(compound), .POWER_SWITCH_CONTROL_O(psw),
    .MGD_SDA_PORT_O(sda), .MGD_SCL_PORT_O(scl));

  // The switches and devices on the far side of the port pins.
  port_switch_model #(.NP(NP)) u_far (.pin_o_i(pin_o), .pin_oe_i(pin_oe), .fault_i(fault),
    .comb_i(comb), .pin_i_o(pin_i), .oc_n_o(oc_n));

  // Free-running 100 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Compares one result; X or Z never passes thanks to case inequality.
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp)
      begin
        bad_count = bad_count + 1;
        $display("BAD %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // Waits whole cycles, then lets the edge's updates settle before sampling.
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask

  // One register write; each channel is released at its own handshake edge.
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= 3'h7;
      do
      begin
        @(posedge clk);
        if (awready)
          awvalid <= 1'b0;
        if (wready)
          wvalid <= 1'b0;
      end
      while (!bvalid);
      chk({30'h0, bresp}, {30'h0, `RESP_OK});
      bready <= 1'b0;
    end
  endtask

  // One register read, compared with the expected data and response.
  task rchk(input [7:0] a, input [31:0] e, input [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    begin
      @(posedge clk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      do
      begin
        @(posedge clk);
        if (arready)
          arvalid <= 1'b0;
      end
      while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      chk(d, e);
      chk({30'h0, r}, {30'h0, er});
    end
  endtask

  // Compares all five charging profile enables at once.
  task chg(input [3:0] v, input [3:0] a2, input [3:0] b, input [3:0] s, input [3:0] l);
    begin
      chk(vend, v);
      chk(vend2a, a2);
      chk(bc12, b);
      chk(shrt, s);
      chk(leg, l);
    end
  endtask

  // Prints the verdict and stops; shared by the main flow and the watchdog.
  task finish_test;
    begin
      if (bad_count == 0 && n_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  // Cuts a hang short well after the tests should have ended.
  initial
  begin
    #300000;
    bad_count = bad_count + 1;
    finish_test;
  end

  // Main sequence; straps keep port 1 disabled until the strap override is set.
  initial
  begin
    {bad_count, n_checks} = '0;
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, dcp, pwr_req, fault, comb} = '0;
    {inhibit_n, gpio} = 9'h1FF;
    strap_dis = 4'h2;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    cyc(3);
    chk(pdis, 4'h2);
    rchk(`A_CTRL, `CTRL_RST, `RESP_OK);
    rchk(`A_PORTCFG, `PORTCFG_RST, `RESP_OK);
    rchk(`A_MISC, `MISC_RST, `RESP_OK);
    rchk(`A_STRLEN, {4{`STR_MAX}}, `RESP_OK);
    rchk(`A_VIDDID, {DIDV, VIDV}, `RESP_OK);
    rchk(8'h1C, 32'h0, `RESP_ERR);
    wr(`A_STRLEN, 32'hFFFFFFFF);
    rchk(`A_STRLEN, {4{`STR_MAX}}, `RESP_OK);
    wr(`A_PID, 32'h3C3C5A5A);
    rchk(`A_PID, 32'h3C3C5A5A, `RESP_OK);
    wr(`A_CTRL, 32'h1);
    cyc(3);
    chk(pdis, 4'h0);
    wr(`A_MISC, 32'hBA5);
    cyc(3);
    chk(swap, 8'hA5);
    chk({scl, sda}, 4'hB);
    wr(`A_PORTCFG, 32'h1000);
    cyc(3);
    chk(compound, 1'b1);
    // Charging on all ports, legacy on port 3, high current on port 1.
    wr(`A_PORTCFG, 32'h28F);
    @(posedge clk);
    dcp <= 4'hF;
    cyc(3);
    chg(4'h7, 4'h2, 4'h7, 4'h7, 4'h8);
    @(posedge clk);
    dcp <= 4'h0;
    cyc(3);
    chg(4'h0, 4'h0, 4'h7, 4'h0, 4'h0);
    // Port 2 on a managed switch keeps charging through the inhibit.
    wr(`A_PORTCFG, 32'h4000028F);
    @(posedge clk);
    dcp <= 4'hF;
    inhibit_n <= 1'b0;
    cyc(3);
    chg(4'h4, 4'h0, 4'h4, 4'h4, 4'h0);
    @(posedge clk);
    inhibit_n <= 1'b1;
    cyc(3);
    chg(4'h7, 4'h2, 4'h7, 4'h7, 4'h8);
    // Power ganging holds only while no port charges.
    wr(`A_PORTCFG, 32'h0);
    wr(`A_CTRL, 32'h3);
    @(posedge clk);
    pwr_req <= 4'h1;
    cyc(3);
    chk(pin_o, 4'hF);
    wr(`A_PORTCFG, 32'h1);
    cyc(3);
    chk(pin_o, 4'h1);
    rchk(`A_STATUS, 32'h00201100, `RESP_OK);
    // Port 0 in combined wiring: released while powered, fault pulls the pin low.
    wr(`A_PORTCFG, 32'h100000);
    wr(`A_CTRL, 32'h1);
    @(posedge clk);
    comb <= 4'h1;
    cyc(3);
    chk(pin_oe, 4'hE);
    @(posedge clk);
    fault <= 4'h1;
    cyc(8);
    chk(oc2, 4'h1);
    @(posedge clk);
    {fault, pwr_req} <= 8'h00;
    cyc(3);
    chk({pin_oe, pin_o}, 8'hF0);
    @(posedge clk);
    comb <= 4'h0;
    // Each first-hub filter length: a held fault is not reported just short of it, and is reported a little after.
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(`A_CTRL, 32'h1 | (i << 6));
      @(posedge clk);
      fault <= 4'h8;
      cyc(OC2N[i] - 2);
      chk(oc2, 4'h0);
      cyc(6);
      chk(oc2, 4'h8);
      @(posedge clk);
      fault <= 4'h0;
      cyc(OC2N[i] + 5);
    end
    wr(`A_CTRL, 32'h201);
    @(posedge clk);
    fault <= 4'h8;
    cyc(`CYC_UP(`OC3_T2_NS) - 2);
    chk(oc3, 4'h0);
    cyc(6);
    chk(oc3, 4'h8);
    @(posedge clk);
    fault <= 4'h0;
    cyc(10);
    wr(`A_CTRL, 32'h5);
    @(posedge clk);
    fault <= 4'h2;
    cyc(10);
    chk(oc2, 4'hF);
    @(posedge clk);
    fault <= 4'h0;
    cyc(10);
    // Split gang of ports 0 and 1 fed from input 2, which is active low.
    wr(`A_PORTCFG, 32'h03000000);
    wr(`A_CTRL, 32'h809);
    @(posedge clk);
    gpio <= 8'hFB;
    cyc(10);
    chk(oc2, 4'h3);
    @(posedge clk);
    gpio <= 8'hFF;
    // Power-on time of three units; the first unit may be as short as one cycle.
    wr(`A_CTRL, 32'h30001);
    @(posedge clk);
    pwr_req <= 4'hF;
    cyc(15);
    chk(pgood, 4'h0);
    cyc(30);
    chk(pgood, 4'hF);
    @(posedge clk);
    pwr_req <= 4'h0;
    wr(`A_CTRL, 32'h30031);
    @(posedge clk);
    pwr_req <= 4'hF;
    cyc(3);
    chk(pgood, 4'hF);
    chk(psw, 1'b1);
    finish_test;
  end
endmodule // chgport_cfg_tb

bind chgport_cfg chgport_props #(.NP(NP)) u_props (.MCLK_I, .RST_N_I, .PORT_DCP_I, .OC_N_I,
  .GPIO_I, .PORT_POWER_CONTROL_PIN_I, .PORT_POWER_CONTROL_PIN_OE_O, .CHG_VENDOR_O,
  .CHG_VENDOR_2A_O, .CHG_BC12_O, .CHG_SHORT_O, .CHG_LEGACY_O, .OC2_REPORT_O, .OC3_REPORT_O);
`default_nettype wire

/* File: sim/chgport_props.sv */
// Property checker for the charging port configuration block.
`timescale 1ns/100ps
`default_nettype none
module chgport_props #(
  parameter NP = 4
) (
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  input wire logic [NP-1:0] PORT_DCP_I,
  input wire logic [NP-1:0] OC_N_I,
  input wire logic [7:0] GPIO_I,
  input wire logic [NP-1:0] PORT_POWER_CONTROL_PIN_I,
  input wire logic [NP-1:0] PORT_POWER_CONTROL_PIN_OE_O,
  input wire logic [NP-1:0] CHG_VENDOR_O,
  input wire logic [NP-1:0] CHG_VENDOR_2A_O,
  input wire logic [NP-1:0] CHG_BC12_O,
  input wire logic [NP-1:0] CHG_SHORT_O,
  input wire logic [NP-1:0] CHG_LEGACY_O,
  input wire logic [NP-1:0] OC2_REPORT_O,
  input wire logic [NP-1:0] OC3_REPORT_O
);
  // Any overcurrent source at all; kept wide so that ganging never raises a false alarm.
  wire oc_any;
  assign oc_any = ~&OC_N_I | ~&GPIO_I | |(~PORT_POWER_CONTROL_PIN_I & ~PORT_POWER_CONTROL_PIN_OE_O);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  legacy_excl_a: assert property ((CHG_LEGACY_O & CHG_VENDOR_O) == '0)
    else $error("legacy and vendor profile active together");
  vendor_dcp_a: assert property ((CHG_VENDOR_O & ~$past(PORT_DCP_I)) == '0)
    else $error("vendor profile outside dedicated charging");
  short_dcp_a: assert property ((CHG_SHORT_O & ~$past(PORT_DCP_I)) == '0)
    else $error("shorted emulation outside dedicated charging");
  legacy_dcp_a: assert property ((CHG_LEGACY_O & ~$past(PORT_DCP_I)) == '0)
    else $error("legacy drive outside dedicated charging");
  vendor_bc_a: assert property ((CHG_VENDOR_O & ~CHG_BC12_O) == '0)
    else $error("vendor profile without handshaking");
  amp_sel_a: assert property ((CHG_VENDOR_2A_O & ~CHG_VENDOR_O) == '0)
    else $error("high current choice without vendor profile");
  oc2_filter_a: assert property ($rose(|OC2_REPORT_O) |-> $past(oc_any, 2) && $past(oc_any, 5))
    else $error("first hub overcurrent accepted too early");
  oc3_filter_a: assert property ($rose(|OC3_REPORT_O) |-> $past(oc_any, 2) && $past(oc_any, 75))
    else $error("second hub overcurrent accepted too early");
endmodule // chgport_props
`default_nettype wire

/* File: sim/port_switch_model.sv */
// Downstream power switches as the board wires them to the port power pins.
`timescale 1ns/100ps
`default_nettype none
module port_switch_model #(
  parameter NP = 4
) (
  input wire logic [NP-1:0] pin_o_i,
  input wire logic [NP-1:0] pin_oe_i,
  input wire logic [NP-1:0] fault_i,
  input wire logic [NP-1:0] comb_i,
  output wire logic [NP-1:0] pin_i_o,
  output wire logic [NP-1:0] oc_n_o
);
  // A released shared pin rises through the pull-up unless the switch flags a fault.
  assign pin_i_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ~fault_i);
  // In combined wiring the flag goes to the shared pin, so the separate input idles high.
  assign oc_n_o = ~(fault_i & ~comb_i);
endmodule // port_switch_model
`default_nettype wire

/* File: verilog/chgport_cfg.v */
// Charging port, port power and overcurrent configuration with AXI4-Lite registers.
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "chgport_defs.vh"
`default_nettype none
module chgport_cfg #(
  parameter NP = 4,
  parameter TICK_CYC = `PG_UNIT_NS / `CLK_PERIOD_NS,
  parameter [15:0] VID_RST = 16'h1234, // Arbitrary identity value.
  parameter [15:0] DID_RST = 16'h0001, // Arbitrary identity value.
  parameter [15:0] PID2_RST = 16'h0002, // Arbitrary identity value.
  parameter [15:0] PID3_RST = 16'h0003 // Arbitrary identity value.
) (
  input wire MCLK_I,
  input wire RST_N_I,
  input wire [7:0] S_AXI_AWADDR_I,
  input wire S_AXI_AWVALID_I,
  output reg S_AXI_AWREADY_O,
  input wire [31:0] S_AXI_WDATA_I,
  input wire [3:0] S_AXI_WSTRB_I,
  input wire S_AXI_WVALID_I,
  output reg S_AXI_WREADY_O,
  output reg [1:0] S_AXI_BRESP_O,
  output reg S_AXI_BVALID_O,
  input wire S_AXI_BREADY_I,
  input wire [7:0] S_AXI_ARADDR_I,
  input wire S_AXI_ARVALID_I,
  output reg S_AXI_ARREADY_O,
  output reg [31:0] S_AXI_RDATA_O,
  output reg [1:0] S_AXI_RRESP_O,
  output reg S_AXI_RVALID_O,
  input wire S_AXI_RREADY_I,
  input wire GLOBAL_CHARGE_INHIBIT_N_I,
  input wire [NP-1:0] STRAP_DISABLE_I,
  input wire [NP-1:0] STRAP_NONREM_I,
  input wire [NP-1:0] STRAP_CHARGE_I,
  input wire [NP-1:0] PORT_DCP_I,
  input wire [NP-1:0] PORT_PWR_REQ_I,
  input wire [NP-1:0] OC_N_I,
  input wire [7:0] GPIO_I,
  input wire [NP-1:0] PORT_POWER_CONTROL_PIN_I,
  output reg [NP-1:0] PORT_POWER_CONTROL_PIN_O,
  output reg [NP-1:0] PORT_POWER_CONTROL_PIN_OE_O,
  output reg [NP-1:0] CHG_VENDOR_O,
  output reg [NP-1:0] CHG_VENDOR_2A_O,
  output reg [NP-1:0] CHG_BC12_O,
  output reg [NP-1:0] CHG_SHORT_O,
  output reg [NP-1:0] CHG_LEGACY_O,
  output reg [NP-1:0] OC2_REPORT_O,
  output reg [NP-1:0] OC3_REPORT_O,
  output reg [NP-1:0] POWER_GOOD_O,
  output reg [NP-1:0] PORT_DISABLE_O,
  output reg [7:0] DPDM_SWAP_O,
  output reg COMPOUND_O,
  output reg POWER_SWITCH_CONTROL_O,
  output reg [1:0] MGD_SDA_PORT_O,
  output reg [1:0] MGD_SCL_PORT_O
);
  reg [31:0] ctrl; // Global mode and timing controls.
  reg [31:0] portcfg; // Per-port fields, four bits each.
  reg [31:0] misc; // Swap and managed switch pin choices.
  reg [31:0] viddid; // Vendor ID low, device ID high.
  reg [31:0] pid; // USB 2.0 product ID low, USB 3.0 high.
  reg [4*`STR_W-1:0] strlen; // Manufacturer, USB2 product, USB3 product, serial.
  reg aw_held, w_held; // Address or data taken, awaiting the other half or the response.
  reg [7:0] aw_addr; // Latched write address.
  reg [31:0] w_data; // Latched write data.
  reg [3:0] w_strb; // Latched byte strobes.
  reg [NP-1:0] strap_dis_q, strap_nrem_q, strap_chg_q; // Straps caught just after reset.
  reg strap_taken; // Straps are caught once per reset.
  reg [17:0] tick_cnt; // Divider for the 2 ms power-on unit.
  reg tick; // One-cycle enable every 2 ms.
  reg [31:0] next_rdata; // Read mux result.
  reg next_rok; // Address is mapped.
  reg [31:0] lim2, lim3; // Filter lengths in cycles per hub; the filters take the low bits.
  wire [NP-1:0] cfg_chg = portcfg[`P_CHG +: NP];
  wire [NP-1:0] cfg_leg = portcfg[`P_LEG +: NP];
  wire [NP-1:0] cfg_a2 = portcfg[`P_A2 +: NP];
  wire [NP-1:0] cfg_comb = portcfg[`P_COMB +: NP];
  wire [NP-1:0] cfg_gmem = portcfg[`P_GMEM +: NP];
  wire [NP-1:0] cfg_msw = portcfg[`P_MSW +: NP];
  wire [NP-1:0] eff_chg, eff_nrem, eff_dis; // Port settings after strap handling.
  wire [NP-1:0] chg_run; // Charging enabled and not inhibited.
  wire [NP-1:0] pwr_on; // Power enable per port.
  wire [NP-1:0] raw_oc; // Unfiltered overcurrent per port.
  wire [NP-1:0] f2_oc, f3_oc; // Filtered for the USB 2.0 and USB 3.0 hubs.
  wire [NP-1:0] gang_mask; // Ports that share the overcurrent gang.
  wire [NP-1:0] pg; // Power good per port.
  wire any_chg = |eff_chg;
  wire gang_pwr = ctrl[`C_GANG_PWR] & ~any_chg;
  wire oc_all = ctrl[`C_OC_ALL] & ~any_chg;
  wire oc_split = ctrl[`C_OC_SPLIT] & ~any_chg;
  wire conflict = any_chg & (ctrl[`C_GANG_PWR] | ctrl[`C_OC_ALL] | ctrl[`C_OC_SPLIT]);
  wire gpio_oc = ~GPIO_I[ctrl[`C_GPIO_SEL +: 3]];
  wire [7:0] pon = ctrl[`C_NO_PSW] ? 8'h00 : ctrl[`C_PON +: 8];
  wire do_wr = aw_held & w_held & ~S_AXI_BVALID_O;
  wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

  // Straps win unless the strap disable is set; ports then follow the configuration.
  assign eff_chg = ctrl[`C_STRAP_DIS] ? cfg_chg : strap_chg_q;
  assign eff_nrem = ctrl[`C_STRAP_DIS] ? portcfg[`P_NREM +: NP] : strap_nrem_q;
  assign eff_dis = ctrl[`C_STRAP_DIS] ? portcfg[`P_DIS +: NP] : strap_dis_q;
  // Inhibit only reaches ports on standard switches; managed switches keep charging.
  assign chg_run = eff_chg & ~({NP{~GLOBAL_CHARGE_INHIBIT_N_I}} & ~cfg_msw);
  // Ganged power is refused while any port charges.
  assign pwr_on = (gang_pwr ? {NP{|PORT_PWR_REQ_I}} : PORT_PWR_REQ_I) & ~eff_dis;
  // Combined pins fault when pulled low while powered; split gang members use the GPIO.
  assign raw_oc = (((cfg_comb & pwr_on & ~PORT_POWER_CONTROL_PIN_I) | (~cfg_comb & ~OC_N_I))
    & ~({NP{oc_split}} & cfg_gmem)) | ({NP{oc_split & gpio_oc}} & cfg_gmem);
  assign gang_mask = oc_all ? {NP{1'b1}} : (oc_split ? cfg_gmem : {NP{1'b0}});

  // Filter length lookup; the printed order of settings is kept as the code order.
  always @*
  begin
    case (ctrl[`C_OC2_SEL +: 2])
      2'h0: lim2 = `CYC_UP(`OC2_T0_NS);
      2'h1: lim2 = `CYC_UP(`OC2_T1_NS);
      2'h2: lim2 = `CYC_UP(`OC2_T2_NS);
      default: lim2 = `CYC_UP(`OC2_T3_NS);
    endcase
    case (ctrl[`C_OC3_SEL +: 2])
      2'h0: lim3 = `CYC_UP(`OC3_T0_NS);
      2'h1: lim3 = `CYC_UP(`OC3_T1_NS);
      2'h2: lim3 = `CYC_UP(`OC3_T2_NS);
      default: lim3 = `CYC_UP(`OC3_T3_NS);
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < NP; g = g + 1)
    begin : gp
      reg [7:0] pg_cnt; // Power-on units elapsed.
      // Each hub filters the same input with its own length.
      oc_filter #(.CW(11)) u_f2 (
        .clk_i(MCLK_I),
        .rst_n_i(RST_N_I),
        .oc_i(raw_oc[g]),
        .limit_i(lim2[10:0]),
        .oc_o(f2_oc[g])
      );
      oc_filter #(.CW(11)) u_f3 (
        .clk_i(MCLK_I),
        .rst_n_i(RST_N_I),
        .oc_i(raw_oc[g]),
        .limit_i(lim3[10:0]),
        .oc_o(f3_oc[g])
      );
      // Power good follows power on after the configured number of 2 ms units.
      always @(posedge MCLK_I)
      begin
        if (!RST_N_I || !pwr_on[g])
        begin
          pg_cnt <= 8'h00;
        end
        else if (tick && pg_cnt < pon)
        begin
          pg_cnt <= pg_cnt + 8'h01;
        end
      end
      assign pg[g] = pwr_on[g] & (pg_cnt >= pon);
    end
  endgenerate

  // The 2 ms unit is a shared enable pulse so every counter stays on one clock.
  always @(posedge MCLK_I)
  begin
    if (!RST_N_I)
    begin
      tick_cnt <= 18'h00000;
      tick <= 1'b0;
    end
    else if (tick_cnt == TICK_CYC[17:0] - 18'h00001)
    begin
      tick_cnt <= 18'h00000;
      tick <= 1'b1;
    end
    else
    begin
      tick_cnt <= tick_cnt + 18'h00001;
      tick <= 1'b0;
    end
  end

  // Straps are sampled on the first clock after reset release, never under reset.
  always @(posedge MCLK_I)
  begin
    if (!RST_N_I)
    begin
      strap_taken <= 1'b0;
      strap_dis_q <= {NP{1'b0}};
      strap_nrem_q <= {NP{1'b0}};
      strap_chg_q <= {NP{1'b0}};
    end
    else if (!strap_taken)
    begin
      strap_taken <= 1'b1;
      strap_dis_q <= STRAP_DISABLE_I;
      strap_nrem_q <= STRAP_NONREM_I;
      strap_chg_q <= STRAP_CHARGE_I;
    end
  end

  // Write channel: address and data are taken in either order, then one response.
  always @(posedge MCLK_I)
  begin
    if (!RST_N_I)
    begin
      S_AXI_AWREADY_O <= 1'b1;
      S_AXI_WREADY_O <= 1'b1;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= `RESP_OK;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      ctrl <= `CTRL_RST;
      portcfg <= `PORTCFG_RST;
      misc <= `MISC_RST;
      viddid <= {DID_RST, VID_RST};
      pid <= {PID3_RST, PID2_RST};
      strlen <= {4{`STR_MAX}};
    end
    else
    begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
      begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR_I;
        S_AXI_AWREADY_O <= 1'b0;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O)
      begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA_I;
        w_strb <= S_AXI_WSTRB_I;
        S_AXI_WREADY_O <= 1'b0;
      end
      if (do_wr)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O <= `RESP_OK;
        case (aw_addr)
          `A_CTRL: ctrl <= (ctrl & ~wmask) | (w_data & wmask);
          `A_PORTCFG: portcfg <= (portcfg & ~wmask) | (w_data & wmask);
          `A_MISC: misc <= (misc & ~wmask) | (w_data & wmask);
          `A_VIDDID: viddid <= (viddid & ~wmask) | (w_data & wmask);
          `A_PID: pid <= (pid & ~wmask) | (w_data & wmask);
          `A_STRLEN: strlen <= clamp_len((strlen & wmask[19:0]) ^ strlen
            ^ (w_data[19:0] & wmask[19:0]));
          `A_STATUS: S_AXI_BRESP_O <= `RESP_OK; // Read-only; writes are dropped.
          default: S_AXI_BRESP_O <= `RESP_ERR;
        endcase
      end
      if (S_AXI_BVALID_O && S_AXI_BREADY_I)
      begin
        S_AXI_BVALID_O <= 1'b0;
        S_AXI_AWREADY_O <= 1'b1;
        S_AXI_WREADY_O <= 1'b1;
      end
    end
  end

  // Longer string lengths are cut to the descriptor limit rather than refused.
  function [4*`STR_W-1:0] clamp_len;
    input [4*`STR_W-1:0] v;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1)
      begin
        clamp_len[k*`STR_W +: `STR_W] = (v[k*`STR_W +: `STR_W] > `STR_MAX) ?
          `STR_MAX : v[k*`STR_W +: `STR_W];
      end
    end
  endfunction
  // Read mux; unmapped addresses answer with an error and zero data.
  always @*
  begin
    next_rok = 1'b1;
    case (S_AXI_ARADDR_I)
      `A_CTRL: next_rdata = ctrl;
      `A_PORTCFG: next_rdata = portcfg;
      `A_MISC: next_rdata = misc;
      `A_VIDDID: next_rdata = viddid;
      `A_PID: next_rdata = pid;
      `A_STRLEN: next_rdata = {12'h000, strlen};
      `A_STATUS: next_rdata = {10'h000, conflict, COMPOUND_O, 4'h0, pg,
        chg_run, OC3_REPORT_O, OC2_REPORT_O};
      default:
      begin
        next_rdata = 32'h00000000;
        next_rok = 1'b0;
      end
    endcase
  end
  // Read channel: one outstanding read, data one cycle after the address.
  always @(posedge MCLK_I)
  begin
    if (!RST_N_I)
    begin
      S_AXI_ARREADY_O <= 1'b1;
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= 32'h00000000;
      S_AXI_RRESP_O <= `RESP_OK;
    end
    else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
    begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RDATA_O <= next_rdata;
      S_AXI_RRESP_O <= next_rok ? `RESP_OK : `RESP_ERR;
    end
    else if (S_AXI_RVALID_O && S_AXI_RREADY_I)
    begin
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_ARREADY_O <= 1'b1;
    end
  end

  // Port-side outputs, all registered to keep the pins glitch free.
  always @(posedge MCLK_I)
  begin
    if (!RST_N_I)
    begin
      PORT_POWER_CONTROL_PIN_O <= {NP{1'b0}};
      PORT_POWER_CONTROL_PIN_OE_O <= {NP{1'b1}};
      CHG_VENDOR_O <= {NP{1'b0}};
      CHG_VENDOR_2A_O <= {NP{1'b0}};
      CHG_BC12_O <= {NP{1'b0}};
      CHG_SHORT_O <= {NP{1'b0}};
      CHG_LEGACY_O <= {NP{1'b0}};
      OC2_REPORT_O <= {NP{1'b0}};
      OC3_REPORT_O <= {NP{1'b0}};
      POWER_GOOD_O <= {NP{1'b0}};
      PORT_DISABLE_O <= {NP{1'b0}};
      DPDM_SWAP_O <= 8'h00;
      COMPOUND_O <= 1'b0;
      POWER_SWITCH_CONTROL_O <= 1'b0;
      MGD_SDA_PORT_O <= 2'h0;
      MGD_SCL_PORT_O <= 2'h0;
    end
    else
    begin
      // Combined pins are driven low to switch off and released to switch on.
      PORT_POWER_CONTROL_PIN_O <= pwr_on & ~cfg_comb;
      PORT_POWER_CONTROL_PIN_OE_O <= ~(cfg_comb & pwr_on);
      // Vendor and shorted emulation only without traffic; legacy replaces both.
      CHG_VENDOR_O <= chg_run & ~cfg_leg & PORT_DCP_I;
      CHG_VENDOR_2A_O <= chg_run & ~cfg_leg & PORT_DCP_I & cfg_a2;
      CHG_BC12_O <= chg_run & ~cfg_leg;
      CHG_SHORT_O <= chg_run & ~cfg_leg & PORT_DCP_I;
      CHG_LEGACY_O <= chg_run & cfg_leg & PORT_DCP_I;
      // A gang member raises the whole gang; split gangs use the chosen GPIO.
      OC2_REPORT_O <= (gang_mask & {NP{|(f2_oc & gang_mask)}}) | (~gang_mask & f2_oc);
      OC3_REPORT_O <= (gang_mask & {NP{|(f3_oc & gang_mask)}}) | (~gang_mask & f3_oc);
      POWER_GOOD_O <= pg;
      PORT_DISABLE_O <= eff_dis;
      DPDM_SWAP_O <= misc[`M_SWAP +: 8];
      COMPOUND_O <= |eff_nrem;
      POWER_SWITCH_CONTROL_O <= ctrl[`C_NO_PSW] & ctrl[`C_U3_NOSW];
      MGD_SDA_PORT_O <= misc[`M_SDA +: 2];
      MGD_SCL_PORT_O <= misc[`M_SCL +: 2];
    end
  end
endmodule // chgport_cfg
`default_nettype wire

/* File: verilog/chgport_defs.vh */
// Constants for the charging port and port power configuration block.
// Functional notes
// - Concurrent mode runs vendor, BC1.2, shorted emulation together.
// - Vendor and shorted emulation only as dedicated charger.
// - Legacy mode drives DP/DM only as dedicated charger.
// - Inhibit low suspends charging; high resumes configured mode.
// - Inhibit honoured only with standard power switches.
// - Charging ports force per-port power and overcurrent.
// - Vendor 1A/2A profile runs alongside BC1.2 handshaking.
// - Legacy mode overrides the vendor profile selection.
// - Managed switch bus pins selectable among ports 1-4.
// - 16-bit vendor, device and per-hub product IDs.
// - Any non-removable port makes both hubs compound.
// - Each string descriptor limited to 30 characters.
// - Strap disable replaces straps with configured values.
// - Per-port combined enable/overcurrent on one pin.
// - Overcurrent on any gang member reported on all.
// - Split gang takes overcurrent from chosen GPIO.
// - Power ganging drives all ports from one control.
// - No power switches forces zero power-on time.
// - Power-on to power-good counted in 2 ms units.
// - USB 2.0 overcurrent filter 50/1000/200/400 ns.
// - USB 3.0 overcurrent filter 750/10000/1250/1500 ns.
// - Per-port DP/DM swap, index 0 upstream.
`ifndef CHGPORT_DEFS_VH
`define CHGPORT_DEFS_VH
`define CLK_PERIOD_NS 10
`define PG_UNIT_NS 2000000
`define OC2_T0_NS 50
`define OC2_T1_NS 1000
`define OC2_T2_NS 200
`define OC2_T3_NS 400
`define OC3_T0_NS 750
`define OC3_T1_NS 10000
`define OC3_T2_NS 1250
`define OC3_T3_NS 1500
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define A_CTRL 8'h00
`define A_PORTCFG 8'h04
`define A_MISC 8'h08
`define A_VIDDID 8'h0C
`define A_PID 8'h10
`define A_STRLEN 8'h14
`define A_STATUS 8'h18
`define C_STRAP_DIS 0
`define C_GANG_PWR 1
`define C_OC_ALL 2
`define C_OC_SPLIT 3
`define C_NO_PSW 4
`define C_U3_NOSW 5
`define C_OC2_SEL 6
`define C_OC3_SEL 8
`define C_GPIO_SEL 10
`define C_PON 16
`define P_CHG 0
`define P_LEG 4
`define P_A2 8
`define P_NREM 12
`define P_DIS 16
`define P_COMB 20
`define P_GMEM 24
`define P_MSW 28
`define M_SWAP 0
`define M_SDA 8
`define M_SCL 10
`define STR_W 5
`define STR_MAX 5'h1E
`define CTRL_RST 32'h00000000
`define PORTCFG_RST 32'h00000000
`define MISC_RST 32'h00000100
`define RESP_OK 2'h0
`define RESP_ERR 2'h2
`endif

/* File: verilog/oc_filter.v */
// Overcurrent glitch filter that needs a continuous assertion of a set length.
`timescale 1ns/100ps
`default_nettype none
module oc_filter #(
  parameter CW = 11
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire oc_i,
  input wire [CW-1:0] limit_i,
  output reg oc_o
);
  reg [CW-1:0] cnt; // Cycles of unbroken assertion so far.
  wire [CW-1:0] cnt_p1; // Count after this cycle.
  assign cnt_p1 = cnt + {{(CW-1){1'b0}}, 1'b1};

  // Any drop of the input restarts the count, so short pulses never get through.
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      cnt <= {CW{1'b0}};
      oc_o <= 1'b0;
    end
    else if (!oc_i)
    begin
      cnt <= {CW{1'b0}};
      oc_o <= 1'b0;
    end
    else if (cnt_p1 >= limit_i)
    begin
      oc_o <= 1'b1;
    end
    else
    begin
      cnt <= cnt_p1;
    end
  end
endmodule // oc_filter
`default_nettype wire
